// ===== bench/mam_ctrl_model.sv
// positioning controller model: drives current-on, alarm clear and home request pins
module mam_ctrl_model (
    input  wire logic clk_i,
    output logic      current_o,
    output logic      clear_o,
    output logic      home_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        current_o = 1'b0;
        clear_o   = 1'b0;
        home_o    = 1'b0;
    end
    task automatic set_current(input logic v);
        @(posedge clk_i);
        current_o <= v;
    endtask : set_current
    task automatic pulse_clear();
        @(posedge clk_i);
        clear_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        clear_o <= 1'b0;
    endtask : pulse_clear
    // deliberately requests home under a bad-data warning when the bench asks
    task automatic pulse_home();
        @(posedge clk_i);
        home_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        home_o <= 1'b0;
    endtask : pulse_home
endmodule : mam_ctrl_model

// ===== bench/mam_top_bench.sv
// bench: walks every alarm cause, checks status, pins, current, irq and clear
module mam_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, home_req_pin_i, motor_running_i, init_busy_i;
    logic sensor_fault_i, motor_supported_i, nvm_corrupt_i, warn_off_dev_i, warn_bad_data_i;
    logic main_power_ok_i, op_start_i, current_on_pin_i, alarm_clear_input_i, motor_current_o;
    logic brake_engage_o, alarm_o, alarm_led_o, irq_o, b0, b1, b2;
    logic [7:0]  adr_i;
    logic [15:0] shaft_rpm_i, resolution_i;
    logic [31:0] dat_i, dat_o, pos_deviation_i, pulse_freq_i, rd;
    logic [3:0]  sel_i, wsel;
    logic        ready_fn_i, tlc_fn_i, tim_fn_i, prev;
    int          lit;
    // short lamp halves keep one full blink sequence under a hundred cycles
    localparam int HALF = 4;
    int errors = 0;
    int checks = 0;
    localparam logic [7:0] CODE [11] = '{8'h28, 8'h42, 8'h43, 8'h45, 8'h41, 8'h71, 8'h10, 8'h12, 8'h34, 8'h23, 8'h70};
    localparam logic [3:0] BLNK [11] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h9, 4'h7, 4'h4, 4'h4, 4'h2, 4'h3, 4'h6};
    localparam logic [2:0] PAT [11]  = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h7, 3'h4, 3'h4, 3'h2, 3'h3, 3'h6};

    mam_ctrl_model m (.clk_i(clk_i), .current_o(current_on_pin_i), .clear_o(alarm_clear_input_i),
        .home_o(home_req_pin_i));
    mam_top #(.BLINK_HALF_CYC(HALF)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .current_on_pin_i(current_on_pin_i), .alarm_clear_input_i(alarm_clear_input_i),
        .home_req_pin_i(home_req_pin_i), .motor_running_i(motor_running_i), .init_busy_i(init_busy_i),
        .sensor_fault_i(sensor_fault_i), .shaft_rpm_i(shaft_rpm_i), .motor_supported_i(motor_supported_i),
        .nvm_corrupt_i(nvm_corrupt_i), .resolution_i(resolution_i), .pos_deviation_i(pos_deviation_i),
        .warn_off_dev_i(warn_off_dev_i), .warn_bad_data_i(warn_bad_data_i), .pulse_freq_i(pulse_freq_i),
        .main_power_ok_i(main_power_ok_i), .op_start_i(op_start_i), .ready_fn_i(ready_fn_i),
        .tlc_fn_i(tlc_fn_i), .tim_fn_i(tim_fn_i), .motor_current_o(motor_current_o),
        .brake_engage_o(brake_engage_o),
        .alarm_o(alarm_o), .alarm_led_o(alarm_led_o), .ready_or_code_bit0_output_o(b0),
        .torque_limit_or_code_bit1_output_o(b1), .timing_or_code_bit2_output_o(b2), .irq_o(irq_o));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= wsel;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1) begin
            errors++;
            test_done();
        end
    endtask : wb

    // cause index i drives exactly one alarm source, except 5, whose cause comes from resolution_i at reset; -1 gives a quiet plant
    task automatic set_cause(input int i);
        sensor_fault_i    <= (i == 0 || i == 1);
        motor_running_i   <= (i == 0);
        init_busy_i       <= (i == 1 || i == 2);
        shaft_rpm_i       <= (i == 2) ? 16'h000f : 16'h0000;
        motor_supported_i <= (i != 3);
        nvm_corrupt_i     <= (i == 4);
        pos_deviation_i   <= (i == 6) ? 32'h0000_1001 : 32'h0000_0000;
        warn_off_dev_i    <= (i == 7);
        pulse_freq_i      <= (i == 8) ? 32'h0007_a121 : 32'h0000_0000;
        main_power_ok_i   <= (i != 9);
        op_start_i        <= (i == 9);
        warn_bad_data_i   <= (i == 10);
    endtask : set_cause

    initial begin
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        adr_i <= 8'h00;
        dat_i <= 32'h0000_0000;
        sel_i <= 4'hf;
        wsel = 4'hf;
        for (int i = 0; i < 11; i++) begin
            rst_i <= 1'b1;
            set_cause(-1);
            resolution_i <= (i == 5) ? 16'h2711 : 16'h03e8;
            {tim_fn_i, tlc_fn_i, ready_fn_i} <= 3'(i + 5);
            m.set_current(i != 7);
            repeat (3) @(posedge clk_i);
            rst_i <= 1'b0;
            if (i == 0) begin
                wb(1'b0, 8'h00, 32'h0);
                chk("ctrl reset", 32'h0, rd);
                wb(1'b0, 8'h10, 32'h0);
                chk("dev limit reset", 32'h0000_1000, rd);
                wb(1'b0, 8'h14, 32'h0);
                chk("pulse max reset", 32'h0007_a120, rd);
                wsel = 4'h1;
                wb(1'b1, 8'h10, 32'hffff_ff55);
                wsel = 4'hf;
                wb(1'b0, 8'h10, 32'h0);
                chk("dev limit lane", 32'h0000_1055, rd);
                wb(1'b0, 8'h3c, 32'h0);
                chk("unmapped read", 32'h0, rd);
            end
            wb(1'b1, 8'h00, 32'h3);
            wb(1'b1, 8'h0c, 32'h1);
            if (i != 5)
                chk("normal pins", {29'h0, 3'(i + 5)}, {29'h0, b2, b1, b0});
            set_cause(i);
            if (i == 7)
                m.set_current(1'b1);
            if (i == 10)
                m.pulse_home();
            for (int n = 0; n < 40 && alarm_o !== 1'b1; n++)
                @(posedge clk_i);
            if (alarm_o !== 1'b1) begin
                errors++;
                test_done();
            end
            set_cause(-1);
            pulse_freq_i <= 32'h0007_a121;
            repeat (6) @(posedge clk_i);
            wb(1'b0, 8'h04, 32'h0);
            chk("status", {14'h0, i == 10, i > 5, 1'b1, PAT[i], BLNK[i], CODE[i]}, rd);
            pulse_freq_i <= 32'h0000_0000;
            chk("code pins", {29'h0, PAT[i]}, {29'h0, b2, b1, b0});
            chk("motor current", {31'h0, i == 10}, {31'h0, motor_current_o});
            chk("brake", {31'h0, i != 10}, {31'h0, brake_engage_o});
            // any window of one full lamp period holds exactly one rise per blink
            prev = alarm_led_o;
            lit = 0;
            for (int k = 0; k < (2 * BLNK[i] + 4) * HALF; k++) begin
                @(posedge clk_i);
                lit += int'(alarm_led_o === 1'b1 && prev === 1'b0);
                prev = alarm_led_o;
            end
            chk("lamp blinks", {28'h0, BLNK[i]}, 32'(lit));
            chk("irq raised", 32'h1, {31'h0, irq_o});
            wb(1'b1, 8'h08, 32'h1);
            repeat (3) @(posedge clk_i);
            chk("irq cleared", 32'h0, {31'h0, irq_o});
            if (i == 3 || i == 8) begin
                wb(1'b1, 8'h00, 32'h7);
                wb(1'b0, 8'h00, 32'h0);
                chk("ctrl reset bit", 32'h3, rd);
            end else
                m.pulse_clear();
            repeat (10) @(posedge clk_i);
            chk("alarm after clear", {31'h0, i < 6}, {31'h0, alarm_o});
            wb(1'b0, 8'h08, 32'h0);
            chk("irq cleared bit", {30'h0, i > 5, 1'b0}, rd);
            $display("test %0d done", i);
        end
        test_done();
    end
endmodule : mam_top_bench

// ===== common/mam_led_if.sv
// interface: blink request and lamp level between monitor and blinker
interface mam_led_if;
    logic       active;
    logic [3:0] blinks;
    logic       led;
    modport owner   (output active, output blinks, input led);
    modport blinker (input active, input blinks, output led);
endinterface : mam_led_if

// ===== common/mam_pkg.sv
// package: constants, alarm table and register map of the alarm monitor
package mam_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ           = 50_000_000;
    localparam int BLINK_HALF_MS    = 200;
    localparam int BLINK_HALF_CYC   = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int BLINK_GAP_HALVES = 4;

    // ----------------------------------------------------------------
    // detection limits
    // ----------------------------------------------------------------
    localparam logic [15:0] ROTOR_RPM_MIN = 16'h000f;
    localparam logic [15:0] RES_MIN       = 16'h0064;
    localparam logic [15:0] RES_MAX       = 16'h2710;

    // ----------------------------------------------------------------
    // alarm indices, lowest index wins when several arrive together
    // ----------------------------------------------------------------
    localparam int NALM        = 11;
    localparam int A_SENS_RUN  = 0;
    localparam int A_SENS_INIT = 1;
    localparam int A_ROTOR     = 2;
    localparam int A_MOTOR     = 3;
    localparam int A_NVM       = 4;
    localparam int A_GEAR      = 5;
    localparam int A_DEV_ON    = 6;
    localparam int A_DEV_OFF   = 7;
    localparam int A_PULSE     = 8;
    localparam int A_MAIN      = 9;
    localparam int A_HOME      = 10;

    // ----------------------------------------------------------------
    // register map (byte offsets) and fields
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0c;
    localparam logic [7:0]  OFS_DEV_LIMIT = 8'h10;
    localparam logic [7:0]  OFS_PULSE_MAX = 8'h14;
    localparam int          CTRL_CODE_EN  = 0;
    localparam int          CTRL_BRAKE    = 1;
    localparam int          CTRL_RESET    = 2;
    localparam int          IRQ_RAISED    = 0;
    localparam int          IRQ_CLEARED   = 1;
    localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
    localparam logic [31:0] DEV_LIMIT_RST = 32'h0000_1000;
    localparam logic [31:0] PULSE_MAX_RST = 32'h0007_a120;

    typedef struct packed {
        logic [7:0] code;
        logic [3:0] blinks;
        logic [2:0] pat;
        logic       energ;
        logic       resettable;
    } mam_alarm_t;

    function automatic mam_alarm_t alarm_info(input logic [3:0] idx);
        case (idx)
            4'h0:    alarm_info = '{8'h28, 4'h8, 3'h0, 1'b0, 1'b0};
            4'h1:    alarm_info = '{8'h42, 4'h8, 3'h0, 1'b0, 1'b0};
            4'h2:    alarm_info = '{8'h43, 4'h8, 3'h0, 1'b0, 1'b0};
            4'h3:    alarm_info = '{8'h45, 4'h8, 3'h0, 1'b0, 1'b0};
            4'h4:    alarm_info = '{8'h41, 4'h9, 3'h1, 1'b0, 1'b0};
            4'h5:    alarm_info = '{8'h71, 4'h7, 3'h7, 1'b0, 1'b0};
            4'h6:    alarm_info = '{8'h10, 4'h4, 3'h4, 1'b0, 1'b1};
            4'h7:    alarm_info = '{8'h12, 4'h4, 3'h4, 1'b0, 1'b1};
            4'h8:    alarm_info = '{8'h34, 4'h2, 3'h2, 1'b0, 1'b1};
            4'h9:    alarm_info = '{8'h23, 4'h3, 3'h3, 1'b0, 1'b1};
            default: alarm_info = '{8'h70, 4'h6, 3'h6, 1'b1, 1'b1};
        endcase
    endfunction : alarm_info
endpackage : mam_pkg

// ===== src/mam_blink.sv
// alarm lamp: n blinks then a dark gap, repeated while an alarm stands
module mam_blink #(
    parameter int HALF_CYC = mam_pkg::BLINK_HALF_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    mam_led_if.blinker led
);
    logic [31:0] tick_reg;
    logic [5:0]  half_reg;
    logic [5:0]  last;

    assign last = {1'b0, led.blinks, 1'b0} + 6'(mam_pkg::BLINK_GAP_HALVES) - 6'h01;

    always_ff @(posedge clk_i) begin
        if (rst_i || !led.active) begin
            tick_reg <= '0;
            half_reg <= '0;
            led.led  <= 1'b0;
        end else begin
            if (tick_reg == 32'(HALF_CYC - 1)) begin
                tick_reg <= '0;
                half_reg <= (half_reg >= last) ? 6'h00 : half_reg + 6'h01;
            end else begin
                tick_reg <= tick_reg + 32'h1;
            end
            // lit on even halves of the counted part only
            led.led <= !half_reg[0] && (half_reg < {1'b0, led.blinks, 1'b0});
        end
    end
endmodule : mam_blink

// ===== src/mam_sync.sv
// two-flop synchroniser for pin inputs
module mam_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule : mam_sync

// ===== src/mam_top.sv
// alarm monitor: detection, latch, clear, code pins, lamp, irq, wishbone
// Summary of operation
// - sensor fault running gives 28, eight blinks
// - sensor fault at power-on gives 42
// - shaft turning during init gives 43
// - unsupported motor gives 45, power-cycle only
// - corrupt stored data gives 41, nine blinks
// - de-energizing alarms cut current, engage brake
// - energized-class alarm keeps motor current on
// - resolution out of range at power-on alarms
// - deviation above limit with current on alarms
// - current-on during off-deviation warning alarms
// - home request during bad-data warning alarms
// - command pulse frequency above maximum alarms
// - starting without main power alarms
// - clear input falling edge resets resettable alarms
// - code outputs show pattern when enabled and an alarm stands
module mam_top #(
    parameter int BLINK_HALF_CYC = mam_pkg::BLINK_HALF_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        current_on_pin_i,
    input  wire logic        alarm_clear_input_i,
    input  wire logic        home_req_pin_i,
    input  wire logic        motor_running_i,
    input  wire logic        init_busy_i,
    input  wire logic        sensor_fault_i,
    input  wire logic [15:0] shaft_rpm_i,
    input  wire logic        motor_supported_i,
    input  wire logic        nvm_corrupt_i,
    input  wire logic [15:0] resolution_i,
    input  wire logic [31:0] pos_deviation_i,
    input  wire logic        warn_off_dev_i,
    input  wire logic        warn_bad_data_i,
    input  wire logic [31:0] pulse_freq_i,
    input  wire logic        main_power_ok_i,
    input  wire logic        op_start_i,
    input  wire logic        ready_fn_i,
    input  wire logic        tlc_fn_i,
    input  wire logic        tim_fn_i,
    output logic             motor_current_o,
    output logic             brake_engage_o,
    output logic             alarm_o,
    output logic             alarm_led_o,
    output logic             ready_or_code_bit0_output_o,
    output logic             torque_limit_or_code_bit1_output_o,
    output logic             timing_or_code_bit2_output_o,
    output logic             irq_o
);
    localparam int N = mam_pkg::NALM;

    function automatic logic [3:0] first_set(input logic [N-1:0] v);
        first_set = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 4'(i);
            end
        end
    endfunction : first_set

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            o[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
        end
        merge = o;
    endfunction : merge

    // ----------------------------------------------------------------
    // pin synchronisers and edges
    // ----------------------------------------------------------------
    logic [2:0] pin_s;
    logic       con_s;
    logic       clr_s;
    logic       home_s;
    logic       con_prev_reg;
    logic       clr_prev_reg;
    logic       home_prev_reg;

    mam_sync #(.W(3)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({home_req_pin_i, alarm_clear_input_i, current_on_pin_i}),
        .q_o   (pin_s)
    );
    assign con_s  = pin_s[0];
    assign clr_s  = pin_s[1];
    assign home_s = pin_s[2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            con_prev_reg  <= 1'b0;
            clr_prev_reg  <= 1'b0;
            home_prev_reg <= 1'b0;
        end else begin
            con_prev_reg  <= con_s;
            clr_prev_reg  <= clr_s;
            home_prev_reg <= home_s;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] dev_limit_reg;
    logic [31:0] pulse_max_reg;
    logic [1:0]  irq_stat_reg;
    logic [1:0]  irq_mask_reg;
    logic        wr;
    logic        sw_reset;

    assign wr       = cyc_i && stb_i && we_i && !ack_o;
    assign sw_reset = wr && (adr_i == mam_pkg::OFS_CTRL) && sel_i[0] && dat_i[mam_pkg::CTRL_RESET];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg      <= mam_pkg::CTRL_RST;
            dev_limit_reg <= mam_pkg::DEV_LIMIT_RST;
            pulse_max_reg <= mam_pkg::PULSE_MAX_RST;
            irq_mask_reg  <= 2'h0;
        end else if (wr) begin
            if (adr_i == mam_pkg::OFS_CTRL) begin
                ctrl_reg <= merge(ctrl_reg, dat_i, sel_i) & 32'h0000_0003;
            end else if (adr_i == mam_pkg::OFS_IRQ_MASK) begin
                irq_mask_reg <= sel_i[0] ? dat_i[1:0] : irq_mask_reg;
            end else if (adr_i == mam_pkg::OFS_DEV_LIMIT) begin
                dev_limit_reg <= merge(dev_limit_reg, dat_i, sel_i);
            end else if (adr_i == mam_pkg::OFS_PULSE_MAX) begin
                pulse_max_reg <= merge(pulse_max_reg, dat_i, sel_i);
            end
        end
    end

    // ----------------------------------------------------------------
    // detection
    // ----------------------------------------------------------------
    logic [N-1:0] det;
    logic         pon_reg;

    // only the first cycle after reset counts as power-on for the gear check
    always_ff @(posedge clk_i) begin
        pon_reg <= rst_i;
    end

    always_comb begin
        det = '0;
        det[mam_pkg::A_SENS_RUN]  = sensor_fault_i && motor_running_i && !init_busy_i;
        det[mam_pkg::A_SENS_INIT] = sensor_fault_i && init_busy_i;
        det[mam_pkg::A_ROTOR]     = init_busy_i && (shaft_rpm_i >= mam_pkg::ROTOR_RPM_MIN);
        det[mam_pkg::A_MOTOR]     = !motor_supported_i;
        det[mam_pkg::A_NVM]       = nvm_corrupt_i;
        det[mam_pkg::A_GEAR]      = pon_reg && ((resolution_i < mam_pkg::RES_MIN) ||
                                                (resolution_i > mam_pkg::RES_MAX));
        det[mam_pkg::A_DEV_ON]    = con_s && (pos_deviation_i > dev_limit_reg);
        det[mam_pkg::A_DEV_OFF]   = con_s && !con_prev_reg && warn_off_dev_i;
        det[mam_pkg::A_HOME]      = home_s && !home_prev_reg && warn_bad_data_i;
        det[mam_pkg::A_PULSE]     = pulse_freq_i > pulse_max_reg;
        det[mam_pkg::A_MAIN]      = op_start_i && !main_power_ok_i;
    end

    // ----------------------------------------------------------------
    // alarm latch
    // ----------------------------------------------------------------
    logic               act_reg;
    mam_pkg::mam_alarm_t cur_reg;
    logic               raise_ev;
    logic               clear_ev;

    assign raise_ev = !act_reg && (|det);
    // reset on the clear input's falling edge, resettable class only
    assign clear_ev = act_reg && cur_reg.resettable && ((clr_prev_reg && !clr_s) || sw_reset);

    // first alarm held until a permitted reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_reg <= 1'b0;
            cur_reg <= '0;
        end else if (raise_ev) begin
            act_reg <= 1'b1;
            cur_reg <= mam_pkg::alarm_info(first_set(det));
        end else if (clear_ev) begin
            act_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // motor current, brake and code pins
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            motor_current_o <= 1'b0;
            brake_engage_o  <= 1'b0;
            alarm_o         <= 1'b0;
        end else begin
            // de-energizing alarm drops current; energized keeps it
            motor_current_o <= con_s && !(act_reg && !cur_reg.energ);
            brake_engage_o  <= ctrl_reg[mam_pkg::CTRL_BRAKE] && !(con_s && !(act_reg && !cur_reg.energ));
            alarm_o         <= act_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_or_code_bit0_output_o        <= 1'b0;
            torque_limit_or_code_bit1_output_o <= 1'b0;
            timing_or_code_bit2_output_o       <= 1'b0;
        end else if (ctrl_reg[mam_pkg::CTRL_CODE_EN] && act_reg) begin
            ready_or_code_bit0_output_o        <= cur_reg.pat[0];
            torque_limit_or_code_bit1_output_o <= cur_reg.pat[1];
            timing_or_code_bit2_output_o       <= cur_reg.pat[2];
        end else begin
            ready_or_code_bit0_output_o        <= ready_fn_i;
            torque_limit_or_code_bit1_output_o <= tlc_fn_i;
            timing_or_code_bit2_output_o       <= tim_fn_i;
        end
    end

    // ----------------------------------------------------------------
    // lamp
    // ----------------------------------------------------------------
    mam_led_if led ();
    assign led.active  = act_reg;
    assign led.blinks  = cur_reg.blinks;
    assign alarm_led_o = led.led;

    mam_blink #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .led   (led.blinker)
    );

    // ----------------------------------------------------------------
    // interrupt: set wins over a write-one clear in the same cycle
    // ----------------------------------------------------------------
    logic [1:0] irq_w1c;
    assign irq_w1c = (wr && adr_i == mam_pkg::OFS_IRQ_STAT && sel_i[0]) ? dat_i[1:0] : 2'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= 2'h0;
            irq_o        <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_w1c) | {clear_ev, raise_ev};
            irq_o        <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ----------------------------------------------------------------
    // wishbone answer: ack one cycle after the request, unmapped reads 0
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            if (adr_i == mam_pkg::OFS_CTRL) begin
                dat_o <= ctrl_reg;
            end else if (adr_i == mam_pkg::OFS_STATUS) begin
                dat_o <= {14'h0, motor_current_o, cur_reg.resettable, act_reg,
                          cur_reg.pat, cur_reg.blinks, cur_reg.code};
            end else if (adr_i == mam_pkg::OFS_IRQ_STAT) begin
                dat_o <= {30'h0, irq_stat_reg};
            end else if (adr_i == mam_pkg::OFS_IRQ_MASK) begin
                dat_o <= {30'h0, irq_mask_reg};
            end else if (adr_i == mam_pkg::OFS_DEV_LIMIT) begin
                dat_o <= dev_limit_reg;
            end else if (adr_i == mam_pkg::OFS_PULSE_MAX) begin
                dat_o <= pulse_max_reg;
            end else begin
                dat_o <= 32'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_new(int i);
        !act_reg && (|det) && first_set(det) == 4'(i);
    endsequence

    sequence s_dark;
        act_reg && !cur_reg.energ;
    endsequence

    chk_run_sensor: assert property (s_new(0) |=> cur_reg.code == 8'h28 && cur_reg.blinks == 4'h8
        && cur_reg.pat == 3'h0 ##1 !motor_current_o) else $error("run sensor alarm wrong");
    chk_init_sensor: assert property (s_new(1) |=> cur_reg.code == 8'h42 && !cur_reg.resettable)
        else $error("init sensor alarm wrong");
    chk_rotor_turn: assert property (s_new(2) |=> act_reg && cur_reg.code == 8'h43)
        else $error("rotor alarm wrong");
    chk_no_clear: assert property (act_reg && !cur_reg.resettable |=> act_reg && $stable(cur_reg))
        else $error("unresettable alarm cleared");
    chk_nvm_code: assert property (s_new(4) |=> cur_reg.code == 8'h41 && cur_reg.blinks == 4'h9
        && cur_reg.pat == 3'h1) else $error("nvm alarm wrong");
    chk_dark_cut: assert property (s_dark ##1 s_dark |-> !motor_current_o
        && (brake_engage_o == ctrl_reg[1] || $changed(ctrl_reg))) else $error("current not cut");
    chk_energ_hold: assert property (act_reg && cur_reg.energ && con_s |=> motor_current_o)
        else $error("energized alarm lost current");
    chk_gear_pon: assert property (s_new(5) |-> pon_reg ##1 cur_reg.code == 8'h71)
        else $error("gear alarm outside power-on");
    chk_dev_limit: assert property (s_new(6) |-> pos_deviation_i > dev_limit_reg ##1
        cur_reg.code == 8'h10) else $error("deviation alarm wrong");
    chk_clear_fall: assert property (act_reg && cur_reg.resettable && clr_prev_reg && !clr_s
        |=> !act_reg) else $error("falling clear ignored");
    chk_code_pins: assert property (ctrl_reg[0] && act_reg ##1 ctrl_reg[0] && act_reg
        |-> timing_or_code_bit2_output_o == cur_reg.pat[2] && ready_or_code_bit0_output_o == cur_reg.pat[0]
        && torque_limit_or_code_bit1_output_o == cur_reg.pat[1])
        else $error("code pattern wrong");
    chk_hold_first: assert property (act_reg && !clear_ev |=> act_reg && $stable(cur_reg.code))
        else $error("latched alarm changed");
endmodule : mam_top
